// ==== hw/ptq_pkg.sv ====
// constants shared by the pulse trigger qualifier
// assumes a single 100 MHz sampling clock
package ptq_pkg;

  // sampling clock
  localparam int CLK_PERIOD_PS   = 10000;

  // shortest edge transit that can be qualified
  localparam int SLEW_MIN_PS     = 600;
  localparam int SLEW_MIN_CYC    = SLEW_MIN_PS / CLK_PERIOD_PS + 1;

  // narrowest pulse the slew qualifier handles reliably, in ps
  localparam int SLEW_PULSE_MIN_PS = 7500;

  // default field widths
  localparam int CNT_W_DEF       = 16;
  localparam int THR_W_DEF       = 12;
  localparam int NUM_CH          = 4;
  localparam int SRC_W           = 2;

  // reset values
  localparam logic RST_TRIG      = 1'b0;
  localparam logic RST_AT_UPPER  = 1'b0;

  typedef enum logic [1:0] {
    PTQ_CLS_RUNT  = 2'b00,
    PTQ_CLS_WIDTH = 2'b01,
    PTQ_CLS_SLEW  = 2'b10
  } ptq_class_t;

  typedef enum logic [1:0] {
    PTQ_POL_POS    = 2'b00,
    PTQ_POL_NEG    = 2'b01,
    PTQ_POL_EITHER = 2'b10
  } ptq_pol_t;

  typedef enum logic [1:0] {
    PTQ_ST_IDLE = 2'b00,
    PTQ_ST_UP   = 2'b01,
    PTQ_ST_DN   = 2'b10
  } ptq_state_t;

endpackage : ptq_pkg

// ==== hw/ptq_qualifier.sv ====
// pulse trigger qualifier: runt, width and slew classes on one channel
// assumes comparator outputs arrive asynchronously and that the
// configuration inputs are stable logic on ref_clk
//
// What this block does
// - runt positive: lower up, lower down, upper never; negative mirrors.
// - runt either: cross one threshold, recross it, other never crossed.
// - runt trigger fires when the first-crossed threshold is recrossed.
// - runt may fire always, or only when wider than a set width.
// - width fires inside lower..upper range, or outside it when selected.
// - width class only knows positive or negative pulses.
// - upper limit is the largest, lower the smallest valid width.
// - effective lower width limit never exceeds the upper limit.
// - one source selection of four channels serves every class.
// - slew positive evaluates edges crossing lower then upper.
// - slew negative evaluates edges crossing upper then lower.
// - slew either evaluates edges crossing one threshold then the other.
// - slew reference is threshold difference over delta time, read only.
// - a select bit picks faster-than or slower-than slew triggering.
// - transits crossing both thresholds in one sample never produce a slew trigger.
// - slew trigger point is the threshold crossed last.
`timescale 1ns/10ps
`default_nettype none

module ptq_qualifier
  import ptq_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF,
  parameter int THR_W = THR_W_DEF
)
(
  input  wire logic               ref_clk,         // sampling clock
  input  wire logic               arst_n,          // async reset, low
  input  wire logic [NUM_CH-1:0]  aboveLower,      // comparator, per chan
  input  wire logic [NUM_CH-1:0]  aboveUpper,      // comparator, per chan
  input  wire logic [SRC_W-1:0]   srcSel,          // trigger source
  input  wire ptq_class_t         trigClass,       // runt, width, slew
  input  wire ptq_pol_t           trigPol,         // polarity
  input  wire logic               runtWidthEn,     // runt wider-than mode
  input  wire logic [CNT_W-1:0]   runtWidth,       // runt width, cycles
  input  wire logic               widthOutside,    // out-of-limits mode
  input  wire logic [CNT_W-1:0]   widthLowerLim,   // lower limit, cycles
  input  wire logic [CNT_W-1:0]   widthUpperLim,   // upper limit, cycles
  input  wire logic [CNT_W-1:0]   deltaTime,       // slew delta, cycles
  input  wire logic [THR_W-1:0]   thrUpper,        // upper threshold code
  input  wire logic [THR_W-1:0]   thrLower,        // lower threshold code
  input  wire logic               slewFaster,      // 1 faster, 0 slower
  output logic                    trigOut,         // trigger pulse
  output logic                    trigAtUpper,     // point at upper thr
  output logic [CNT_W-1:0]        slewRef,         // slew reference
  output logic [CNT_W-1:0]        effLowerLim      // constrained lower
);

  logic                rstMeta;
  logic                rstN;
  logic [NUM_CH-1:0]   loMeta;
  logic [NUM_CH-1:0]   hiMeta;
  logic [NUM_CH-1:0]   loSync;
  logic [NUM_CH-1:0]   hiSync;
  logic                loPrev;
  logic                hiPrev;
  logic                lo;
  logic                hi;
  logic                loRise;
  logic                loFall;
  logic                hiRise;
  logic                hiFall;
  logic                cfgChanged;
  logic                posOk;
  logic                negOk;
  logic                widthNeg;
  logic                inRange;
  logic                slewOk;
  logic                runtOk;
  logic [CNT_W-1:0]    lowerClamp;
  logic [CNT_W-1:0]    thrDiff;
  logic [CNT_W-1:0]    cnt_reg;
  logic [CNT_W-1:0]    cnt_next;
  ptq_state_t          state_reg;
  ptq_state_t          state_next;
  logic                trig_reg;
  logic                trig_next;
  logic                atUpper_reg;
  logic                atUpper_next;
  logic [CNT_W-1:0]    slewRef_reg;
  logic [CNT_W-1:0]    slewRef_next;
  logic [CNT_W-1:0]    effLower_reg;
  logic [CNT_W-1:0]    effLower_next;
  ptq_class_t          clsPrev_reg;
  ptq_pol_t            polPrev_reg;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // all channels synchronised before the source mux, so switching
  // source never exposes a metastable first stage
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      loMeta <= '0;
      hiMeta <= '0;
      loSync <= '0;
      hiSync <= '0;
    end
    else
    begin
      loMeta <= aboveLower;
      hiMeta <= aboveUpper;
      loSync <= loMeta;
      hiSync <= hiMeta;
    end
  end

  assign lo = loSync[srcSel];
  assign hi = hiSync[srcSel];

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      loPrev      <= 1'b0;
      hiPrev      <= 1'b0;
      clsPrev_reg <= PTQ_CLS_RUNT;
      polPrev_reg <= PTQ_POL_POS;
    end
    else
    begin
      loPrev      <= lo;
      hiPrev      <= hi;
      clsPrev_reg <= trigClass;
      polPrev_reg <= trigPol;
    end
  end

  assign loRise     = lo & ~loPrev;
  assign loFall     = ~lo & loPrev;
  assign hiRise     = hi & ~hiPrev;
  assign hiFall     = ~hi & hiPrev;
  assign cfgChanged = (trigClass != clsPrev_reg) ||
                      (trigPol != polPrev_reg);
  assign posOk      = (trigPol == PTQ_POL_POS) ||
                      (trigPol == PTQ_POL_EITHER);
  assign negOk      = (trigPol == PTQ_POL_NEG) ||
                      (trigPol == PTQ_POL_EITHER);
  // either is not offered for width; it falls back to positive
  assign widthNeg   = (trigPol == PTQ_POL_NEG);

  assign lowerClamp = (widthLowerLim > widthUpperLim) ?
                      widthUpperLim : widthLowerLim;
  assign inRange    = (cnt_reg >= lowerClamp) &&
                      (cnt_reg <= widthUpperLim);
  assign runtOk     = !runtWidthEn || (cnt_reg > runtWidth);
  // cycle counts compared directly, no ratio arithmetic per edge
  assign slewOk     = (cnt_reg >= CNT_W'(SLEW_MIN_CYC)) &&
                      (slewFaster ? (cnt_reg < deltaTime)
                                  : (cnt_reg > deltaTime));

  // sequence tracker, shared by the classes since only one is active
  always_comb
  begin
    state_next   = state_reg;
    cnt_next     = (&cnt_reg) ? cnt_reg : cnt_reg + 1'b1;
    trig_next    = 1'b0;
    atUpper_next = atUpper_reg;
    if (cfgChanged)
    begin
      state_next = PTQ_ST_IDLE;
    end
    else
    begin
      case (trigClass)
        PTQ_CLS_RUNT:
        begin
          case (state_reg)
            PTQ_ST_IDLE:
            begin
              if (posOk && loRise && !hi)
              begin
                state_next = PTQ_ST_UP;
                cnt_next   = CNT_W'(1);
              end
              else if (negOk && hiFall && lo)
              begin
                state_next = PTQ_ST_DN;
                cnt_next   = CNT_W'(1);
              end
            end
            PTQ_ST_UP:
            begin
              if (hiRise)
                state_next = PTQ_ST_IDLE;
              else if (loFall)
              begin
                state_next   = PTQ_ST_IDLE;
                trig_next    = runtOk;
                atUpper_next = 1'b0;
              end
            end
            PTQ_ST_DN:
            begin
              if (loFall)
                state_next = PTQ_ST_IDLE;
              else if (hiRise)
              begin
                state_next   = PTQ_ST_IDLE;
                trig_next    = runtOk;
                atUpper_next = 1'b1;
              end
            end
            default: state_next = PTQ_ST_IDLE;
          endcase
        end
        PTQ_CLS_WIDTH:
        begin
          case (state_reg)
            PTQ_ST_IDLE:
            begin
              if (!widthNeg && loRise)
              begin
                state_next = PTQ_ST_UP;
                cnt_next   = CNT_W'(1);
              end
              else if (widthNeg && loFall)
              begin
                state_next = PTQ_ST_DN;
                cnt_next   = CNT_W'(1);
              end
            end
            PTQ_ST_UP:
            begin
              if (loFall)
              begin
                state_next   = PTQ_ST_IDLE;
                trig_next    = inRange ^ widthOutside;
                atUpper_next = 1'b0;
              end
            end
            PTQ_ST_DN:
            begin
              if (loRise)
              begin
                state_next   = PTQ_ST_IDLE;
                trig_next    = inRange ^ widthOutside;
                atUpper_next = 1'b0;
              end
            end
            default: state_next = PTQ_ST_IDLE;
          endcase
        end
        PTQ_CLS_SLEW:
        begin
          case (state_reg)
            PTQ_ST_IDLE:
            begin
              // both crossing in one sample is too fast to qualify
              if (posOk && loRise && !hiRise)
              begin
                state_next = PTQ_ST_UP;
                cnt_next   = CNT_W'(1);
              end
              else if (negOk && hiFall && !loFall)
              begin
                state_next = PTQ_ST_DN;
                cnt_next   = CNT_W'(1);
              end
            end
            PTQ_ST_UP:
            begin
              if (loFall)
                state_next = PTQ_ST_IDLE;
              else if (hiRise)
              begin
                state_next   = PTQ_ST_IDLE;
                trig_next    = slewOk;
                atUpper_next = 1'b1;
              end
            end
            PTQ_ST_DN:
            begin
              if (hiRise)
                state_next = PTQ_ST_IDLE;
              else if (loFall)
              begin
                state_next   = PTQ_ST_IDLE;
                trig_next    = slewOk;
                atUpper_next = 1'b0;
              end
            end
            default: state_next = PTQ_ST_IDLE;
          endcase
        end
        default: state_next = PTQ_ST_IDLE;
      endcase
    end
  end

  // reference readout; a zero delta saturates instead of dividing
  assign thrDiff = (thrUpper > thrLower) ?
                   CNT_W'(thrUpper - thrLower) : '0;

  always_comb
  begin
    slewRef_next  = (deltaTime == '0) ? '1 : thrDiff / deltaTime;
    effLower_next = lowerClamp;
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_reg    <= PTQ_ST_IDLE;
      cnt_reg      <= '0;
      trig_reg     <= RST_TRIG;
      atUpper_reg  <= RST_AT_UPPER;
      slewRef_reg  <= '0;
      effLower_reg <= '0;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      trig_reg     <= trig_next;
      atUpper_reg  <= atUpper_next;
      slewRef_reg  <= slewRef_next;
      effLower_reg <= effLower_next;
    end
  end

  assign trigOut     = trig_reg;
  assign trigAtUpper = atUpper_reg;
  assign slewRef     = slewRef_reg;
  assign effLowerLim = effLower_reg;

  default clocking cbAssert @(posedge ref_clk);
  endclocking

  default disable iff (!rstN);

  sequence s_armed;
    state_reg != PTQ_ST_IDLE;
  endsequence

  sequence s_fire;
    trig_reg;
  endsequence

  // pulse and point register together, so the point is judged in the
  // pulse cycle against the crossing seen one cycle earlier
  sequence s_runtFire;
    s_armed ##1 s_fire ##0 $past(trigClass) == PTQ_CLS_RUNT;
  endsequence

  a_trig_single: assert property (s_fire |=> !trig_reg)
    else $error("trigger longer than one cycle");

  a_trig_armed: assert property (s_fire |->
    $past(state_reg) != PTQ_ST_IDLE && state_reg == PTQ_ST_IDLE)
    else $error("trigger without armed tracker");

  a_cfg_idle: assert property (cfgChanged |=>
    state_reg == PTQ_ST_IDLE && !trig_reg)
    else $error("tracker not idled on setting change");

  a_runt_abort: assert property (
    trigClass == PTQ_CLS_RUNT && state_reg == PTQ_ST_UP && hiRise &&
    !cfgChanged |=> state_reg == PTQ_ST_IDLE && !trig_reg)
    else $error("runt fired after upper crossing");

  a_runt_point: assert property (s_runtFire |->
    ($past(state_reg) == PTQ_ST_UP ? $past(loFall) && !trigAtUpper
                                   : $past(hiRise) && trigAtUpper))
    else $error("runt trigger at wrong crossing");

  a_slew_point: assert property (
    trig_reg && trigClass == PTQ_CLS_SLEW |-> trigAtUpper == $past(hiRise))
    else $error("slew trigger point wrong");

  a_slew_min: assert property (
    trig_reg && trigClass == PTQ_CLS_SLEW |->
    $past(cnt_reg) >= CNT_W'(SLEW_MIN_CYC))
    else $error("slew trigger on too fast an edge");

  a_slew_cmp: assert property (
    trig_reg && trigClass == PTQ_CLS_SLEW && $stable(slewFaster) |->
    (slewFaster ? $past(cnt_reg) < $past(deltaTime)
                : $past(cnt_reg) > $past(deltaTime)))
    else $error("slew comparison direction wrong");

  a_width_range: assert property (
    trig_reg && trigClass == PTQ_CLS_WIDTH && $stable(widthOutside) |->
    (($past(cnt_reg) >= $past(lowerClamp) &&
      $past(cnt_reg) <= $past(widthUpperLim)) != widthOutside))
    else $error("width trigger outside selected range");

  a_lower_clamp: assert property (
    ##1 effLower_reg <= $past(widthUpperLim))
    else $error("lower limit above upper limit");

endmodule : ptq_qualifier

`default_nettype wire

// ==== testbench/ptq_comp_model.sv ====
// threshold comparator pair per input channel, the far side of the block
// assumes 8-bit channel levels driven by the bench
`timescale 1ns/10ps
`default_nettype none

module ptq_comp_model
  import ptq_pkg::*;
#(
  parameter logic [7:0] THR_LO = 8'h28,
  parameter logic [7:0] THR_HI = 8'h50
)
(
  input  wire logic [8*NUM_CH-1:0] level,      // channel levels
  output logic      [NUM_CH-1:0]   aboveLower, // above lower threshold
  output logic      [NUM_CH-1:0]   aboveUpper  // above upper threshold
);
  // plain level compare; pulse width is left to the stimulus
  always_comb
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      aboveLower[ch] = level[ch*8 +: 8] > THR_LO;
      aboveUpper[ch] = level[ch*8 +: 8] > THR_HI;
    end
  end
endmodule : ptq_comp_model

`default_nettype wire

// ==== testbench/tb_pulse_trigger_qualifier.sv ====
// self-checking bench for the pulse trigger qualifier
// assumes ptq_comp_model stands between bench levels and the design
`timescale 1ns/10ps
`default_nettype none

module tb_pulse_trigger_qualifier
  import ptq_pkg::*;
;
  localparam logic [15:0] LO_LIM = 16'h0005;
  localparam logic [15:0] HI_LIM = 16'h000A;
  localparam logic [15:0] DT     = 16'h0006;
  localparam logic [15:0] RW     = 16'h0004;

  logic        ref_clk       = 1'b0;
  logic        arst_n        = 1'b0;
  logic [31:0] lvl           = 32'h0000_0000;
  logic [3:0]  aboveLower;
  logic [3:0]  aboveUpper;
  logic [1:0]  srcSel        = 2'h0;
  ptq_class_t  trigClass     = PTQ_CLS_RUNT;
  ptq_pol_t    trigPol       = PTQ_POL_POS;
  logic        runtWidthEn   = 1'b0;
  logic        widthOutside  = 1'b0;
  logic [15:0] widthLowerLim = LO_LIM;
  logic [15:0] deltaTime     = DT;
  logic [11:0] thrUpper      = 12'h050;
  logic        slewFaster    = 1'b0;
  logic        trigOut;
  logic        trigAtUpper;
  logic [15:0] slewRef;
  logic [15:0] effLowerLim;
  logic [1:0]  band          = 2'h0;
  logic [31:0] rnd           = 32'h0001_31FB;
  int          failures      = 0;
  int          check_count   = 0;
  logic        expQ[$];

  always #5 ref_clk = ~ref_clk;

  ptq_comp_model compModel (
    .level      (lvl),
    .aboveLower (aboveLower),
    .aboveUpper (aboveUpper)
  );

  ptq_qualifier uut (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .aboveLower    (aboveLower),
    .aboveUpper    (aboveUpper),
    .srcSel        (srcSel),
    .trigClass     (trigClass),
    .trigPol       (trigPol),
    .runtWidthEn   (runtWidthEn),
    .runtWidth     (RW),
    .widthOutside  (widthOutside),
    .widthLowerLim (widthLowerLim),
    .widthUpperLim (HI_LIM),
    .deltaTime     (deltaTime),
    .thrUpper      (thrUpper),
    .thrLower      (12'h028),
    .slewFaster    (slewFaster),
    .trigOut       (trigOut),
    .trigAtUpper   (trigAtUpper),
    .slewRef       (slewRef),
    .effLowerLim   (effLowerLim)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // 0 below lower, 1 between, 2 above upper, with noise inside the band
  function automatic logic [7:0] bandLevel(input logic [1:0] b,
                                           input logic [7:0] r);
    case (b)
      2'h0:    return {3'h0, r[4:0]};
      2'h1:    return 8'h30 + {4'h0, r[3:0]};
      default: return 8'h60 + {2'h0, r[5:0]};
    endcase
  endfunction : bandLevel

  // unselected channels toggle at random to show they are ignored
  always @(posedge ref_clk)
  begin
    rnd = xs(rnd);
    for (int ch = 0; ch < 4; ch++)
    begin
      if (ch == srcSel)
        lvl[ch*8 +: 8] <= bandLevel(band, rnd[ch*8 +: 8]);
      else
        lvl[ch*8 +: 8] <= rnd[ch*8 +: 8];
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // idle class first, so a new source cannot leave a tracker armed
  task automatic run(input ptq_class_t c, input ptq_pol_t p,
                     input logic [1:0] b0, input logic [1:0] b1,
                     input int d, input logic [1:0] b2,
                     input logic fire, input logic up);
    @(posedge ref_clk);
    trigClass <= ptq_class_t'(2'h3);
    srcSel    <= rnd[9:8];
    band      <= b0;
    repeat (6) @(posedge ref_clk);
    trigClass <= c;
    trigPol   <= p;
    if (fire)
      expQ.push_back(up);
    repeat (6) @(posedge ref_clk);
    band <= b1;
    repeat (d) @(posedge ref_clk);
    band <= b2;
    repeat (10) @(posedge ref_clk);
    check(16'(expQ.size()), 16'h0000, "pending triggers");
    $display("test class %0d pol %0d done", c, p);
  endtask : run

  always @(posedge ref_clk)
  begin
    if (trigOut === 1'b1)
    begin
      if (expQ.size() == 0)
        check(16'h0001, 16'h0000, "unexpected trigger");
      else
        check(trigAtUpper, expQ.pop_front(), "trigAtUpper");
    end
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    stop_test();
  end

  initial
  begin
    int wl[4];
    wl = '{4, 5, 10, 11};
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check(slewRef, (16'h0050 - 16'h0028) / DT, "slewRef");
    thrUpper <= 12'h028;
    repeat (2) @(posedge ref_clk);
    check(slewRef, 16'h0000, "slewRef flat");
    thrUpper  <= 12'h050;
    deltaTime <= 16'h0000;
    repeat (2) @(posedge ref_clk);
    check(slewRef, 16'hFFFF, "slewRef zero delta");
    deltaTime     <= DT;
    widthLowerLim <= 16'h000C;
    repeat (2) @(posedge ref_clk);
    check(effLowerLim, HI_LIM, "effLowerLim clamp");
    widthLowerLim <= LO_LIM;
    repeat (2) @(posedge ref_clk);
    check(effLowerLim, LO_LIM, "effLowerLim");
    $display("test readouts done");
    run(PTQ_CLS_RUNT, PTQ_POL_POS, 0, 1, 5, 0, 1, 0);
    run(PTQ_CLS_RUNT, PTQ_POL_POS, 0, 1, 5, 2, 0, 0);
    run(PTQ_CLS_RUNT, PTQ_POL_NEG, 2, 1, 5, 2, 1, 1);
    run(PTQ_CLS_RUNT, PTQ_POL_NEG, 2, 1, 5, 0, 0, 0);
    run(PTQ_CLS_RUNT, PTQ_POL_EITHER, 0, 1, 5, 0, 1, 0);
    run(PTQ_CLS_RUNT, PTQ_POL_EITHER, 2, 1, 5, 2, 1, 1);
    runtWidthEn <= 1'b1;
    for (int d = 4; d < 6; d++)
      run(PTQ_CLS_RUNT, PTQ_POL_POS, 0, 1, d, 0, d > RW, 0);
    runtWidthEn <= 1'b0;
    for (int o = 0; o < 2; o++)
    begin
      widthOutside <= o[0];
      foreach (wl[i])
        run(PTQ_CLS_WIDTH, PTQ_POL_POS, 0, 1, wl[i], 0,
            ((wl[i] >= LO_LIM) && (wl[i] <= HI_LIM)) ^ o[0], 0);
    end
    widthOutside <= 1'b0;
    run(PTQ_CLS_WIDTH, PTQ_POL_NEG, 1, 0, 7, 1, 1, 0);
    run(PTQ_CLS_WIDTH, PTQ_POL_EITHER, 0, 1, 7, 0, 1, 0);
    for (int f = 0; f < 2; f++)
    begin
      slewFaster <= f[0];
      for (int d = 5; d < 8; d++)
        run(PTQ_CLS_SLEW, PTQ_POL_POS, 0, 1, d, 2,
            f ? (d < DT) : (d > DT), 1);
    end
    run(PTQ_CLS_SLEW, PTQ_POL_NEG, 2, 1, 3, 0, 1, 0);
    run(PTQ_CLS_SLEW, PTQ_POL_NEG, 2, 1, 3, 2, 0, 0);
    run(PTQ_CLS_SLEW, PTQ_POL_POS, 0, 1, 3, 0, 0, 1);
    run(PTQ_CLS_SLEW, PTQ_POL_EITHER, 0, 1, 3, 2, 1, 1);
    run(PTQ_CLS_SLEW, PTQ_POL_EITHER, 2, 1, 3, 0, 1, 0);
    // both thresholds in one sample: transit too short to qualify
    run(PTQ_CLS_SLEW, PTQ_POL_POS, 0, 2, 3, 2, 0, 1);
    stop_test();
  end
endmodule : tb_pulse_trigger_qualifier

`default_nettype wire
